// ==== rsc_pkg.sv ====
// Package for the reset source controller: offsets, fields, timing, types
package rsc_pkg;

   // Register word offsets (byte addresses, word index = offset / 4)
   localparam logic [3:0] OFF_STATUS_0  = 4'h0;
   localparam logic [3:0] OFF_STATUS_1  = 4'h4;
   localparam logic [3:0] OFF_STATUS_2  = 4'h8;
   localparam logic [3:0] OFF_CONFIG    = 4'hc;

   // reset_status_0 fields
   localparam int POS_POWERON = 0;
   localparam int POS_LVD0   = 1;
   localparam int POS_LVD1   = 2;
   localparam int POS_LVD2   = 3;
   localparam int POS_DPSR   = 4;
   // reset_status_1 fields
   localparam int POS_IWDF   = 0;
   localparam int POS_WDF    = 1;
   localparam int POS_SWF    = 2;
   localparam int POS_SRPF   = 3;
   localparam int POS_SREF   = 4;
   localparam int POS_BMPF   = 5;
   localparam int POS_BSPF   = 6;
   localparam int POS_SPEF   = 7;
   localparam int POS_TZEF   = 8;
   localparam int POS_CPEF   = 9;
   localparam int POS_BKUPF  = 10;
   // reset_status_2 fields
   localparam int POS_WARM_START = 0;
   // config register fields
   localparam int POS_IWD_NMI = 0;
   localparam int POS_WD_NMI  = 1;
   localparam int POS_LVD_EN  = 2;
   localparam int POS_LVD_RST = 5;
   localparam int POS_BKUP_EN = 8;

   localparam logic [31:0] RST_CONFIG = 32'h0000_0000;

   // Timing, 100 MHz system clock
   localparam int CLK_PERIOD_NS     = 10;
   localparam int POR_HOLD_NS       = 1000;
   localparam int LVD_STAB_NS       = 500;
   localparam int WD_DELAY_NS       = 200;
   localparam int SOFT_HOLD_NS      = 200;
   localparam int STBY_WAIT_CYC     = 35;
   localparam int POR_HOLD_CYC  = (POR_HOLD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int LVD_STAB_CYC  = (LVD_STAB_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int WD_DELAY_CYC  = (WD_DELAY_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int SOFT_HOLD_CYC = (SOFT_HOLD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int CNT_W = 12;

   // Reset sequencer states
   typedef enum logic [3:0] {
      RSC_ST_RUN  = 4'b0001,
      RSC_ST_HOLD = 4'b0010,
      RSC_ST_WAIT = 4'b0100,
      RSC_ST_POR  = 4'b1000
   } rsc_state_t;

   // Fault detector inputs, one-cycle or level requests
   typedef struct packed {
      logic sram_parity;
      logic sram_ecc;
      logic bus_master;
      logic bus_slave;
      logic stack_ptr;
      logic security;
      logic cache_parity;
   } rsc_fault_t;

   // Avalon-MM slave request
   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } rsc_avreq_t;

endpackage

// ==== rsc_reset_ctrl.sv ====
// Reset source controller: combines reset requests, sequences release
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - A low external reset pin aborts everything and holds internal reset.
// R2 - External driver keeps the pin low for the minimum pulse width.
// R3 - Power-on reset while supply is below threshold with the pin high.
// R4 - Power-on release only after supply good plus full hold time.
// R5 - A later supply drop with pin high restarts power-on reset.
// R6 - Power-on sets the power-on flag; a pin reset clears it.
// R7 - Backup-supply switchover may raise its own reset when enabled.
// R8 - Independent watchdog underflow: reset or NMI, flag set, short reset.
// R9 - Window watchdog expiry: reset or NMI, flag set, short reset.
// R10 - Three monitors, each three levels, raise interrupt or reset on drop.
// R11 - Monitor reset releases after supply recovers plus stabilization time.
// R12 - Monitoring disabled after power-on until enabled by option setting.
// R13 - A reset from monitor n sets that monitor's flag.
// R14 - Deep-standby wake: reset, restart oscillator, release after 35 cycles.
// R15 - Deep-standby wake reset sets the deep-standby flag.
// R16 - Core reset request makes a software reset held for the hold time.
// R17 - Warm start flag cleared only by power-on reset.
// R18 - Writing 1 sets the warm start flag; writing 0 leaves it.
// R19 - SRAM parity/ECC, bus master/slave and stack errors raise a reset.
// R20 - Security-partition and cache parity errors also raise a reset.
// R21 - Fault resets need no enable.
// R22 - Reset cause recorded in two status registers, with software flag.
// R23 - Requests combine and internal reset releases on the clock.
module rsc_reset_ctrl (
   input  wire logic                CLOCK,
   input  wire logic                RST_N,
   input  wire logic                EXTERNAL_RESET_PIN_N,
   input  wire logic                SUPPLY_ABOVE_POR,
   input  wire logic                BACKUP_SWITCH,
   input  wire logic                INDEPENDENT_WATCHDOG_UNDERFLOW,
   input  wire logic                WINDOW_WATCHDOG_EXPIRY,
   input  wire logic [2:0]          SUPPLY_ABOVE_MONITOR,
   input  wire logic                STANDBY_WAKE,
   input  wire logic                CORE_RESET_REQUEST,
   input  wire rsc_pkg::rsc_fault_t FAULTS,
   input  wire rsc_pkg::rsc_avreq_t AV_REQ,
   output logic [31:0]              AV_READDATA,
   output logic                     AV_WAITREQUEST,
   output logic                     SYS_RESET_N,
   output logic                     OSC_RESTART,
   output logic                     WATCHDOG_NMI,
   output logic [2:0]               MONITOR_IRQ,
   output logic [5:0]               MONITOR_LEVEL_SEL
);

   logic                  rst_meta_n;
   logic                  rst_n;
   logic                  pin_meta;
   logic                  pin_n;
   logic                  por_meta;
   logic                  supply_ok;
   rsc_pkg::rsc_state_t   state;
   rsc_pkg::rsc_state_t   next_state;
   logic [rsc_pkg::CNT_W-1:0] cnt;
   logic [rsc_pkg::CNT_W-1:0] next_cnt;
   logic [rsc_pkg::CNT_W-1:0] hold_len;
   logic [rsc_pkg::CNT_W-1:0] next_hold_len;
   logic [31:0]           cfg;
   logic [4:0]            stat0;
   logic [10:0]           stat1;
   logic                  warm_start;
   logic                  av_ack;
   logic [2:0]            prev_mon;

   // Reset release through two flip-flops
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // Pin and supply levels resynchronised; only second stage is used
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         // Pin idles high; a low reset value would fake a pin reset
         pin_meta  <= 1'b1;
         pin_n     <= 1'b1;
         por_meta  <= 1'b0;
         supply_ok <= 1'b0;
      end else begin
         pin_meta  <= EXTERNAL_RESET_PIN_N;
         pin_n     <= pin_meta;
         por_meta  <= SUPPLY_ABOVE_POR;
         supply_ok <= por_meta;
      end
   end

   // Request decode
   wire [2:0] lvd_en  = cfg[rsc_pkg::POS_LVD_EN +: 3];
   wire [2:0] lvd_rst = cfg[rsc_pkg::POS_LVD_RST +: 3];
   wire [2:0] mon_low = ~SUPPLY_ABOVE_MONITOR & lvd_en;           // R12
   wire [2:0] mon_rst = mon_low & lvd_rst;                        // R10
   wire iwd_rst = INDEPENDENT_WATCHDOG_UNDERFLOW
                  & ~cfg[rsc_pkg::POS_IWD_NMI];                   // R8
   wire wd_rst  = WINDOW_WATCHDOG_EXPIRY
                  & ~cfg[rsc_pkg::POS_WD_NMI];                    // R9
   wire bk_rst  = BACKUP_SWITCH & cfg[rsc_pkg::POS_BKUP_EN];      // R7
   wire fault_any = |FAULTS;                                      // R19 R20 R21
   wire por_req = pin_n & ~supply_ok;                             // R3 R5
   wire short_req = iwd_rst | wd_rst | bk_rst | fault_any
                    | CORE_RESET_REQUEST;                         // R16
   wire any_req = ~pin_n | por_req | (|mon_rst) | short_req
                  | STANDBY_WAKE;                                 // R23

   // Release length chosen by the latest cause
   always_comb begin
      next_hold_len = hold_len;
      if (STANDBY_WAKE) begin
         next_hold_len = rsc_pkg::CNT_W'(rsc_pkg::STBY_WAIT_CYC); // R14
      end else if (CORE_RESET_REQUEST) begin
         next_hold_len = rsc_pkg::CNT_W'(rsc_pkg::SOFT_HOLD_CYC); // R16
      end else if (iwd_rst | wd_rst | bk_rst | fault_any) begin
         next_hold_len = rsc_pkg::CNT_W'(rsc_pkg::WD_DELAY_CYC);  // R8 R9
      end else if (|mon_rst) begin
         next_hold_len = rsc_pkg::CNT_W'(rsc_pkg::LVD_STAB_CYC);  // R11
      end else if (!pin_n) begin
         next_hold_len = rsc_pkg::CNT_W'(1);
      end
   end

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         rsc_pkg::RSC_ST_RUN: begin
            if (por_req) begin
               next_state = rsc_pkg::RSC_ST_POR;
            end else if (any_req) begin
               next_state = rsc_pkg::RSC_ST_HOLD;
            end
         end
         rsc_pkg::RSC_ST_POR: begin
            next_cnt = '0;
            if (!pin_n) begin
               next_state = rsc_pkg::RSC_ST_HOLD;
            end else if (supply_ok) begin
               next_state = rsc_pkg::RSC_ST_WAIT;
            end
         end
         rsc_pkg::RSC_ST_HOLD: begin
            next_cnt = '0;
            if (por_req) begin
               next_state = rsc_pkg::RSC_ST_POR;
            end else if (!any_req) begin
               next_state = rsc_pkg::RSC_ST_WAIT;                 // R11
            end
         end
         rsc_pkg::RSC_ST_WAIT: begin
            next_cnt = cnt + 1'b1;
            if (por_req) begin
               next_state = rsc_pkg::RSC_ST_POR;                  // R5
            end else if (any_req) begin
               next_state = rsc_pkg::RSC_ST_HOLD;                 // R1
            end else if (cnt + 1'b1 >= hold_len) begin
               next_state = rsc_pkg::RSC_ST_RUN;                  // R4
            end
         end
         default: begin
            next_state = rsc_pkg::RSC_ST_POR;
         end
      endcase
   end

   wire por_active = (state == rsc_pkg::RSC_ST_POR);
   wire por_done = (state == rsc_pkg::RSC_ST_POR) && supply_ok && pin_n;

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state    <= rsc_pkg::RSC_ST_POR;
         cnt      <= '0;
         hold_len <= rsc_pkg::CNT_W'(rsc_pkg::POR_HOLD_CYC);
      end else begin
         state    <= next_state;
         cnt      <= next_cnt;
         hold_len <= por_done ? rsc_pkg::CNT_W'(rsc_pkg::POR_HOLD_CYC)
                              : next_hold_len;                    // R4
      end
   end

   // Internal reset leaves only on a clock edge
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         SYS_RESET_N <= 1'b0;
         OSC_RESTART <= 1'b0;
      end else begin
         SYS_RESET_N <= (next_state == rsc_pkg::RSC_ST_RUN);      // R1 R23
         OSC_RESTART <= STANDBY_WAKE;                             // R14
      end
   end

   // Non-reset events
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         WATCHDOG_NMI <= 1'b0;
         MONITOR_IRQ  <= 3'h0;
         prev_mon     <= 3'h0;
      end else begin
         WATCHDOG_NMI <= (INDEPENDENT_WATCHDOG_UNDERFLOW
                          & cfg[rsc_pkg::POS_IWD_NMI])
                       | (WINDOW_WATCHDOG_EXPIRY
                          & cfg[rsc_pkg::POS_WD_NMI]);            // R8 R9
         prev_mon     <= mon_low;
         MONITOR_IRQ  <= mon_low & ~prev_mon & ~lvd_rst;          // R10
      end
   end

   // Cause flags: power-on wipes all but the power-on flag, later causes accumulate
   wire [4:0] set0 = {STANDBY_WAKE, mon_rst, 1'b0};               // R13 R15
   wire [10:0] set1 = {bk_rst, FAULTS.cache_parity, FAULTS.security,
                       FAULTS.stack_ptr, FAULTS.bus_slave,
                       FAULTS.bus_master, FAULTS.sram_ecc,
                       FAULTS.sram_parity, CORE_RESET_REQUEST,
                       wd_rst, iwd_rst};                          // R22
   wire wr_cfg = av_ack && AV_REQ.write
                 && AV_REQ.address == rsc_pkg::OFF_CONFIG;
   wire wr_ws  = av_ack && AV_REQ.write && AV_REQ.byteenable[0]
                 && AV_REQ.address == rsc_pkg::OFF_STATUS_2
                 && AV_REQ.writedata[rsc_pkg::POS_WARM_START];

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         stat0      <= 5'h01;
         stat1      <= 11'h000;
         warm_start <= 1'b0;
         cfg        <= rsc_pkg::RST_CONFIG;
      end else if (por_active) begin
         stat0      <= 5'h01;                                     // R6
         stat1      <= 11'h000;
         warm_start <= 1'b0;                                      // R17
         cfg        <= rsc_pkg::RST_CONFIG;                       // R12
      end else begin
         if (!pin_n) begin
            stat0[rsc_pkg::POS_POWERON] <= 1'b0;                  // R6
         end
         stat0[4:1] <= stat0[4:1] | set0[4:1];
         stat1      <= stat1 | set1;                              // R22
         if (wr_ws) begin
            warm_start <= 1'b1;                                   // R18
         end
         if (wr_cfg) begin
            cfg <= AV_REQ.writedata;
         end
      end
   end

   assign MONITOR_LEVEL_SEL = {cfg[15:14], cfg[13:12], cfg[11:10]}; // R10

   // Avalon slave: one wait cycle on every access
   wire req = AV_REQ.read | AV_REQ.write;
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         av_ack      <= 1'b0;
         AV_READDATA <= 32'h0000_0000;
      end else begin
         av_ack <= req & ~av_ack;
         if (req && !av_ack && AV_REQ.read) begin
            if (AV_REQ.address == rsc_pkg::OFF_STATUS_0) begin
               AV_READDATA <= {27'h0, stat0};
            end else if (AV_REQ.address == rsc_pkg::OFF_STATUS_1) begin
               AV_READDATA <= {21'h0, stat1};
            end else if (AV_REQ.address == rsc_pkg::OFF_STATUS_2) begin
               AV_READDATA <= {31'h0, warm_start};
            end else if (AV_REQ.address == rsc_pkg::OFF_CONFIG) begin
               AV_READDATA <= cfg;
            end else begin
               AV_READDATA <= 32'h0000_0000;
            end
         end
      end
   end
   assign AV_WAITREQUEST = req & ~av_ack;

endmodule

// ==== rsc_reset_ctrl_assertions.sv ====
// Port-level timing checks of the reset source controller
`timescale 1ns/1ps
module rsc_reset_ctrl_chk (
   input wire logic                CLOCK,
   input wire logic                RST_N,
   input wire logic                EXTERNAL_RESET_PIN_N,
   input wire logic                SUPPLY_ABOVE_POR,
   input wire logic                BACKUP_SWITCH,
   input wire logic                INDEPENDENT_WATCHDOG_UNDERFLOW,
   input wire logic                WINDOW_WATCHDOG_EXPIRY,
   input wire logic [2:0]          SUPPLY_ABOVE_MONITOR,
   input wire logic                STANDBY_WAKE,
   input wire logic                CORE_RESET_REQUEST,
   input wire rsc_pkg::rsc_fault_t FAULTS,
   input wire rsc_pkg::rsc_avreq_t AV_REQ,
   input wire logic [31:0]         AV_READDATA,
   input wire logic                AV_WAITREQUEST,
   input wire logic                SYS_RESET_N,
   input wire logic                OSC_RESTART,
   input wire logic                WATCHDOG_NMI,
   input wire logic [2:0]          MONITOR_IRQ,
   input wire logic [5:0]          MONITOR_LEVEL_SEL
);
   // Cycles the supply has stayed good, saturating
   logic [6:0] sup_cnt;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N)
         sup_cnt <= 7'h00;
      else if (!SUPPLY_ABOVE_POR)
         sup_cnt <= 7'h00;
      else if (sup_cnt != 7'h7f)
         sup_cnt <= sup_cnt + 7'h01;
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   pin_hold_a: assert property ((!EXTERNAL_RESET_PIN_N [*5]) |-> !SYS_RESET_N)
      else $error("internal reset free while pin low");
   supply_low_a: assert property ((!SUPPLY_ABOVE_POR [*5]) |-> !SYS_RESET_N)
      else $error("internal reset free while supply low");
   por_hold_a: assert property ($rose(SYS_RESET_N) |-> sup_cnt >= 7'h64)
      else $error("release before supply hold time");
   soft_hold_a: assert property (CORE_RESET_REQUEST && SYS_RESET_N
      |=> !SYS_RESET_N [*8]) else $error("software reset too short");
   stby_wake_a: assert property (STANDBY_WAKE && SYS_RESET_N
      |=> OSC_RESTART && !SYS_RESET_N) else $error("wake without reset");
   fault_rst_a: assert property ((|FAULTS) && SYS_RESET_N
      |=> !SYS_RESET_N) else $error("fault did not reset");
   nmi_only_a: assert property ($rose(WATCHDOG_NMI) |-> SYS_RESET_N)
      else $error("reset taken in interrupt mode");
   irq_pulse_a: assert property ((MONITOR_IRQ != 3'h0)
      |=> (MONITOR_IRQ == 3'h0) && SYS_RESET_N) else $error("bad monitor irq");
   sync_rel_a: assert property ($rose(SYS_RESET_N)
      |-> EXTERNAL_RESET_PIN_N && $past(EXTERNAL_RESET_PIN_N, 3))
      else $error("release not aligned to pin");
   cover property (CORE_RESET_REQUEST && SYS_RESET_N);
   cover property (STANDBY_WAKE && SYS_RESET_N);
   cover property (MONITOR_IRQ != 3'h0);
endmodule

// ==== rsc_far_model.sv ====
// Model of the external reset driver and the supply
`timescale 1ns/1ps
module rsc_far_model #(
   parameter int MIN_PULSE = 8
) (
   input  wire logic CLOCK,
   input  wire logic pin_go,
   input  wire logic supply_on,
   output logic      pin_n,
   output logic      supply_ok
);
   int left = 0;
   // A request always gives a full-width low pulse
   always @(posedge CLOCK) begin
      if (pin_go)
         left <= MIN_PULSE;
      else if (left > 0)
         left <= left - 1;
   end
   // Pin idles high so power-up is seen as power-on
   assign pin_n = (left == 0);
   assign supply_ok = supply_on;
endmodule

// ==== rsc_reset_ctrl_test.sv ====
// Self-checking bench of the reset source controller
`timescale 1ns/1ps
module rsc_reset_ctrl_test;
   typedef struct {int kind; logic [3:0] a; int pos; int hold;} rsc_row_t;
   localparam logic [3:0] S0 = rsc_pkg::OFF_STATUS_0;
   localparam logic [3:0] S1 = rsc_pkg::OFF_STATUS_1;
   localparam logic [3:0] S2 = rsc_pkg::OFF_STATUS_2;
   localparam logic [3:0] CF = rsc_pkg::OFF_CONFIG;
   localparam int         W  = rsc_pkg::WD_DELAY_CYC;
   logic clock = 1'b0, rst_n = 1'b0, pin_go = 1'b0, supply_on = 1'b1;
   logic pin_n, supply_ok, backup = 1'b0, iwd = 1'b0, wwd = 1'b0;
   logic wake = 1'b0, core = 1'b0, waitreq, sys_n, osc, nmi, seen;
   logic [2:0] mon = 3'h7, irq;
   logic [5:0] lvl;
   logic [31:0] rdata, rd;
   rsc_pkg::rsc_fault_t faults = '0;
   rsc_pkg::rsc_avreq_t req = '0;
   int errors = 0, cmp_count = 0, cyc = 0, n;
   rsc_row_t rows [12] = '{
      '{0, S1, rsc_pkg::POS_SWF, rsc_pkg::SOFT_HOLD_CYC},
      '{1, S1, rsc_pkg::POS_IWDF, W}, '{2, S1, rsc_pkg::POS_WDF, W},
      '{3, S1, rsc_pkg::POS_SRPF, W}, '{4, S1, rsc_pkg::POS_SREF, W},
      '{5, S1, rsc_pkg::POS_BMPF, W}, '{6, S1, rsc_pkg::POS_BSPF, W},
      '{7, S1, rsc_pkg::POS_SPEF, W}, '{8, S1, rsc_pkg::POS_TZEF, W},
      '{9, S1, rsc_pkg::POS_CPEF, W}, '{11, S1, rsc_pkg::POS_BKUPF, W},
      '{10, S0, rsc_pkg::POS_DPSR, rsc_pkg::STBY_WAIT_CYC}};
   initial forever #5 clock = ~clock;
   rsc_far_model far (.CLOCK(clock), .pin_go(pin_go), .supply_on(supply_on),
      .pin_n(pin_n), .supply_ok(supply_ok));
   rsc_reset_ctrl dut (.CLOCK(clock), .RST_N(rst_n),
      .EXTERNAL_RESET_PIN_N(pin_n), .SUPPLY_ABOVE_POR(supply_ok),
      .BACKUP_SWITCH(backup), .INDEPENDENT_WATCHDOG_UNDERFLOW(iwd),
      .WINDOW_WATCHDOG_EXPIRY(wwd), .SUPPLY_ABOVE_MONITOR(mon),
      .STANDBY_WAKE(wake), .CORE_RESET_REQUEST(core), .FAULTS(faults),
      .AV_REQ(req), .AV_READDATA(rdata), .AV_WAITREQUEST(waitreq),
      .SYS_RESET_N(sys_n), .OSC_RESTART(osc), .WATCHDOG_NMI(nmi),
      .MONITOR_IRQ(irq), .MONITOR_LEVEL_SEL(lvl));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic we, input logic [3:0] a,
                      input logic [31:0] wd);
      @(posedge clock);
      req.address <= a;
      req.read <= !we;
      req.write <= we;
      req.writedata <= wd;
      req.byteenable <= 4'hf;
      // Request stands until the edge that sees waitrequest low
      do begin
         @(posedge clock);
      end while (waitreq !== 1'b0);
      rd = rdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask
   task automatic rdbit(input logic [3:0] a, input int pos, input logic e);
      bus(1'b0, a, 32'h0);
      check(rd[pos], e);
   endtask
   task automatic fire(input int kind);
      @(posedge clock);
      case (kind)
         0: core <= 1'b1;
         1: iwd <= 1'b1;
         2: wwd <= 1'b1;
         10: wake <= 1'b1;
         11: backup <= 1'b1;
         default: faults <= 7'h40 >> (kind - 3);
      endcase
      @(posedge clock);
      {core, iwd, wwd, wake, backup} <= 5'h00;
      faults <= '0;
   endtask
   // Waits for internal reset, then counts its low cycles
   task automatic low_len(output int len);
      int k;
      k = 0;
      len = 0;
      while (sys_n !== 1'b0 && k < 50) begin
         @(negedge clock);
         k++;
      end
      while (sys_n !== 1'b1 && len < 400) begin
         @(negedge clock);
         len++;
      end
      check(sys_n, 1'b1);
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      low_len(n);
      check(n >= rsc_pkg::POR_HOLD_CYC, 1);
      rdbit(S0, rsc_pkg::POS_POWERON, 1'b1);
      rdbit(S2, rsc_pkg::POS_WARM_START, 1'b0);
      bus(1'b1, S2, 32'h1);
      rdbit(S2, rsc_pkg::POS_WARM_START, 1'b1);
      bus(1'b1, S2, 32'h0);
      rdbit(S2, rsc_pkg::POS_WARM_START, 1'b1);
      mon <= 3'h6;
      repeat (20) @(negedge clock);
      check(sys_n, 1'b1);
      @(posedge clock);
      mon <= 3'h7;
      bus(1'b1, CF, 32'h9100);
      @(negedge clock);
      check(lvl, 6'h24);
      $display("power-on test done");
      foreach (rows[i]) begin
         fire(rows[i].kind);
         @(negedge clock);
         check(osc, rows[i].kind == 10);
         low_len(n);
         check(n >= rows[i].hold - 2 && n <= rows[i].hold + 4, 1);
         rdbit(rows[i].a, rows[i].pos, 1'b1);
         $display("row %0d done", i);
      end
      bus(1'b1, S1, 32'h0);
      rdbit(S1, rsc_pkg::POS_SWF, 1'b1);
      bus(1'b1, CF, 32'h9103);
      for (int k = 1; k < 3; k++) begin
         fire(k);
         @(negedge clock);
         check({nmi, sys_n}, 2'h3);
      end
      $display("interrupt mode test done");
      @(posedge clock);
      pin_go <= 1'b1;
      @(posedge clock);
      pin_go <= 1'b0;
      low_len(n);
      check(n >= 6, 1);
      rdbit(S0, rsc_pkg::POS_POWERON, 1'b0);
      rdbit(S2, rsc_pkg::POS_WARM_START, 1'b1);
      $display("pin test done");
      bus(1'b1, CF, 32'h913c);
      mon <= 3'h6;
      repeat (20) @(negedge clock);
      check(sys_n, 1'b0);
      @(posedge clock);
      mon <= 3'h7;
      low_len(n);
      check(n >= rsc_pkg::LVD_STAB_CYC, 1);
      rdbit(S0, rsc_pkg::POS_LVD0, 1'b1);
      seen = 1'b0;
      mon <= 3'h5;
      repeat (10) begin
         @(negedge clock);
         seen = seen | irq[1];
      end
      check({seen, sys_n}, 2'h3);
      @(posedge clock);
      mon <= 3'h7;
      $display("monitor test done");
      supply_on <= 1'b0;
      repeat (10) @(negedge clock);
      check(sys_n, 1'b0);
      @(posedge clock);
      supply_on <= 1'b1;
      low_len(n);
      check(n >= rsc_pkg::POR_HOLD_CYC, 1);
      rdbit(S2, rsc_pkg::POS_WARM_START, 1'b0);
      rdbit(S0, rsc_pkg::POS_POWERON, 1'b1);
      $display("supply drop test done");
      close_out();
   end
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_chk chk (.CLOCK(CLOCK), .RST_N(RST_N),
   .EXTERNAL_RESET_PIN_N(EXTERNAL_RESET_PIN_N),
   .SUPPLY_ABOVE_POR(SUPPLY_ABOVE_POR), .BACKUP_SWITCH(BACKUP_SWITCH),
   .INDEPENDENT_WATCHDOG_UNDERFLOW(INDEPENDENT_WATCHDOG_UNDERFLOW),
   .WINDOW_WATCHDOG_EXPIRY(WINDOW_WATCHDOG_EXPIRY),
   .SUPPLY_ABOVE_MONITOR(SUPPLY_ABOVE_MONITOR), .STANDBY_WAKE(STANDBY_WAKE),
   .CORE_RESET_REQUEST(CORE_RESET_REQUEST), .FAULTS(FAULTS), .AV_REQ(AV_REQ),
   .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST),
   .SYS_RESET_N(SYS_RESET_N), .OSC_RESTART(OSC_RESTART),
   .WATCHDOG_NMI(WATCHDOG_NMI), .MONITOR_IRQ(MONITOR_IRQ),
   .MONITOR_LEVEL_SEL(MONITOR_LEVEL_SEL));
